/* File: hdl/adc_ctrl_pkg.sv */
`default_nettype none
package adc_ctrl_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] OFFSET_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFFSET_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFFSET_RESULT_HIGH = 8'h08;
  localparam logic [7:0] OFFSET_RESULT_LOW = 8'h0c;
  localparam logic [7:0] OFFSET_REF_TEMP = 8'h10;
  localparam logic [7:0] OFFSET_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFFSET_IRQ_MASK = 8'h18;

  // converter_control_0 fields.
  localparam int POS_CONVERTER_ENABLE = 0;
  localparam int POS_GO_DONE = 1;
  localparam int POS_CHANNEL_LSB = 2;
  // converter_control_1 fields.
  localparam int POS_POS_REF_LSB = 0;
  localparam int POS_CLOCK_SEL_LSB = 4;
  // voltage_ref_temp_control fields.
  localparam int POS_FIXED_REF_GAIN_LSB = 0;
  localparam int POS_TEMP_RANGE = 4;
  localparam int POS_TEMP_SENSOR_ENABLE = 5;
  localparam int POS_FIXED_REF_READY = 6;
  localparam int POS_FIXED_REF_ENABLE = 7;
  // Interrupt status and mask fields.
  localparam int IRQ_COUNT = 2;
  localparam int POS_IRQ_DONE = 0;
  localparam int POS_IRQ_ABORT = 1;

  localparam logic [7:0] RESET_CONTROL_0 = 8'h00;
  localparam logic [7:0] RESET_CONTROL_1 = 8'h00;
  localparam logic [7:0] RESET_REF_TEMP = 8'h00;
  localparam logic [1:0] RESET_IRQ_MASK = 2'h0;

  localparam int RESULT_WIDTH = 10;
  localparam int CHANNEL_WIDTH = 5;
  localparam logic [4:0] CHANNEL_VREF_POS = 5'h1c;
  localparam logic [4:0] CHANNEL_VREF_NEG = 5'h1d;
  localparam logic [4:0] CHANNEL_TEMP_SENSOR = 5'h1e;
  localparam logic [4:0] CHANNEL_FIXED_REF = 5'h1f;

  localparam logic [1:0] POS_REF_SUPPLY = 2'h0;
  localparam logic [1:0] POS_REF_PIN = 2'h2;
  localparam logic [1:0] POS_REF_FIXED = 2'h3;

  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h6;

  // A conversion lasts 11.5 bit periods, counted in half periods.
  localparam logic [4:0] HALF_PERIODS_PER_CONVERSION = 5'd23;
  localparam logic [4:0] FIRST_DECISION_HALF = 5'd2;
  localparam logic [4:0] LAST_DECISION_HALF = 5'd20;

  typedef struct packed {
    logic temp_sensor_power;
    logic temp_range_high;
    logic fixed_ref_enable;
    logic [1:0] fixed_ref_gain;
    logic [4:0] channel;
    logic [1:0] positive_ref;
    logic sampling;
    logic [9:0] trial_code;
  } analog_ctrl_type;

endpackage
`default_nettype wire

/* File: hdl/conv_clock_gen.sv */
`default_nettype none
module conv_clock_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] clock_select,
  input wire logic rc_osc_tick,
  output logic half_tick
);
  import adc_ctrl_pkg::*;

  logic [4:0] count_reg;
  logic [4:0] limit;
  logic use_rc;

  // Divided sources are counted in pclk cycles, so any change of the system clock scales them alike.
  always_comb begin
    use_rc = (clock_select[1:0] == 2'b11);
    unique case (clock_select)
      CLK_DIV2: limit = 5'd0;
      CLK_DIV4: limit = 5'd1;
      CLK_DIV8: limit = 5'd3;
      CLK_DIV16: limit = 5'd7;
      CLK_DIV32: limit = 5'd15;
      CLK_DIV64: limit = 5'd31;
      default: limit = 5'd0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 5'h00;
    end else if (!run || count_reg == limit) begin
      count_reg <= 5'h00;
    end else begin
      count_reg <= count_reg + 5'd1;
    end
  end

  // The RC source is independent of pclk; each of its ticks marks one half period.
  assign half_tick = run && (use_rc ? rc_osc_tick : (count_reg == limit));

endmodule
`default_nettype wire

/* File: hdl/irq_status_bank.sv */
`default_nettype none
module irq_status_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] event_pulse,
  input wire logic clear_write,
  input wire logic mask_write,
  input wire logic [1:0] write_bits,
  output logic [1:0] status,
  output logic [1:0] mask,
  output logic irq
);
  import adc_ctrl_pkg::*;

  genvar i;
  generate
    for (i = 0; i < IRQ_COUNT; i++) begin : g_bit
      // A new event in the clearing cycle wins, so no completion is lost.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status[i] <= 1'b0;
        end else if (event_pulse[i]) begin
          status[i] <= 1'b1;
        end else if (clear_write && write_bits[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= RESET_IRQ_MASK;
    end else if (mask_write) begin
      mask <= write_bits;
    end
  end

  assign irq = |(status & mask);

endmodule
`default_nettype wire

/* File: hdl/sar_adc_temp_sense_control.sv */
// Function
// - Temperature sensor powered only while its enable bit is set.
// - Range bit one selects high range, zero selects low range.
// - One channel code is reserved for the internal temperature sensor.
// - Ten-bit successive approximation result stored in high and low result registers.
// - Channel field connects one of 21 sources to the sample-and-hold.
// - Positive reference chosen from pin, supply or fixed reference.
// - Conversion clock is system clock over 2 to 64 or the RC oscillator.
// - A full conversion takes 11.5 bit conversion periods.
// - Completion raises an interrupt able to wake the device.
// - Divided clock sources follow system clock changes; RC source does not.
// - Clock select encoding 000,100,001,101,010,110 divides, x11 RC oscillator.
// - Enable bit enables; go written one starts; not in the enabling write.
// - On completion clear go, set done flag, load result registers.
// - Clearing go early stops and stores partial result, unresolved bits copy last.
//
// Our own choices: the register addresses and the APB slave port.
`default_nettype none
module sar_adc_temp_sense_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_high,
  input wire logic rc_osc_tick,
  input wire logic fixed_ref_ready,
  output adc_ctrl_pkg::analog_ctrl_type analog_ctrl,
  output logic irq
);
  import adc_ctrl_pkg::*;

  // One-hot codes; any other code falls back to idle.
  typedef enum logic [1:0] {
    IDLE = 2'b01,
    CONVERT = 2'b10
  } conv_state_type;

  conv_state_type state_reg;
  logic busy;
  logic [7:0] control_0_reg;
  logic [7:0] control_1_reg;
  logic [7:0] ref_temp_reg;
  logic [1:0] result_high_reg;
  logic [7:0] result_low_reg;
  logic [9:0] sar_code_reg;
  logic [9:0] sar_code_next;
  logic [3:0] bit_index_reg;
  logic [4:0] half_count_reg;
  logic last_bit_reg;
  logic [9:0] partial_code;
  logic [31:0] prdata_reg;
  logic [31:0] read_value;
  logic address_hit;
  logic access;
  logic write_access;
  logic write_ctrl0;
  logic write_ctrl1;
  logic write_ref_temp;
  logic write_irq_status;
  logic write_irq_mask;
  logic start_request;
  logic abort_request;
  logic disable_request;
  logic half_tick;
  logic decision_tick;
  logic finish_tick;
  logic conversion_done;
  logic partial_store;
  logic [1:0] irq_events;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  // APB: zero wait states; read data is captured in the setup cycle.
  assign access = psel && penable;
  assign write_access = access && pwrite;
  assign pready = access;
  assign pslverr = access && !address_hit;
  assign prdata = prdata_reg;
  assign write_ctrl0 = write_access && (paddr == OFFSET_CONTROL_0);
  assign write_ctrl1 = write_access && (paddr == OFFSET_CONTROL_1);
  assign write_ref_temp = write_access && (paddr == OFFSET_REF_TEMP);
  assign write_irq_status = write_access && (paddr == OFFSET_IRQ_STATUS);
  assign write_irq_mask = write_access && (paddr == OFFSET_IRQ_MASK);
  assign busy = (state_reg == CONVERT);

  // Go may only start a conversion when the enable bit was already set before this write.
  assign start_request = write_ctrl0 && pwdata[POS_GO_DONE] && control_0_reg[POS_CONVERTER_ENABLE]
    && pwdata[POS_CONVERTER_ENABLE] && !busy;
  // Clearing enable outranks clearing go: the sample is dropped rather than stored in part.
  assign abort_request = write_ctrl0 && !pwdata[POS_GO_DONE] && busy;
  assign disable_request = write_ctrl0 && !pwdata[POS_CONVERTER_ENABLE] && busy;

  // Unmapped offsets read zero and flag an error; writes to them are dropped.
  always_comb begin
    address_hit = 1'b1;
    read_value = 32'h0000_0000;
    unique case (paddr)
      OFFSET_CONTROL_0: begin
        read_value[7:0] = control_0_reg;
        read_value[POS_GO_DONE] = busy;
      end
      OFFSET_CONTROL_1: read_value[7:0] = control_1_reg;
      OFFSET_RESULT_HIGH: read_value[1:0] = result_high_reg;
      OFFSET_RESULT_LOW: read_value[7:0] = result_low_reg;
      OFFSET_REF_TEMP: begin
        read_value[7:0] = ref_temp_reg;
        read_value[POS_FIXED_REF_READY] = fixed_ref_ready;
      end
      OFFSET_IRQ_STATUS: read_value[1:0] = irq_status;
      OFFSET_IRQ_MASK: read_value[1:0] = irq_mask;
      default: address_hit = 1'b0;
    endcase
  end

  // Capturing in the setup cycle keeps the read path off the bus timing in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= read_value;
    end
  end

  // Go is kept apart from the stored control bits; its readback is the busy state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_0_reg <= RESET_CONTROL_0;
    end else if (write_ctrl0) begin
      control_0_reg <= pwdata[7:0] & 8'hfd;
    end
  end

  // Bits 7, 3 and 2 are unimplemented and read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_1_reg <= RESET_CONTROL_1;
    end else if (write_ctrl1) begin
      control_1_reg <= pwdata[7:0] & 8'h73;
    end
  end

  // Bits 3 and 2 are unimplemented and the ready bit is read from the reference itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_temp_reg <= RESET_REF_TEMP;
    end else if (write_ref_temp) begin
      ref_temp_reg <= pwdata[7:0] & 8'hb3;
    end
  end

  // The divider restarts with every conversion, so the first half period is full length except with the RC source, which runs free.
  conv_clock_gen clock_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(busy),
    .clock_select(control_1_reg[POS_CLOCK_SEL_LSB +: 3]),
    .rc_osc_tick(rc_osc_tick),
    .half_tick(half_tick)
  );

  // Half period 0 and 1 hold the sample; decisions fall on even halves 2 to 20; 22 ends it.
  assign decision_tick = half_tick && !half_count_reg[0]
    && half_count_reg >= FIRST_DECISION_HALF && half_count_reg <= LAST_DECISION_HALF;
  assign finish_tick = half_tick && (half_count_reg == HALF_PERIODS_PER_CONVERSION - 5'd1);

  // The bit under trial takes the comparator's answer and the next bit down becomes the new trial.
  always_comb begin
    sar_code_next = sar_code_reg;
    sar_code_next[bit_index_reg] = comparator_high;
    if (bit_index_reg != 4'd0) begin
      sar_code_next[bit_index_reg - 4'd1] = 1'b1;
    end
  end

  genvar b;
  generate
    for (b = 0; b < RESULT_WIDTH; b++) begin : g_partial
      // Bits above the pending trial bit are decided; the rest repeat the last decision, zero before any.
      assign partial_code[b] = (b > int'(bit_index_reg)) ? sar_code_reg[b] : last_bit_reg;
    end
  endgenerate

  // A finished, aborted or disabled conversion returns to idle in one step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= IDLE;
    end else begin
      unique case (state_reg)
        IDLE: begin
          if (start_request) begin
            state_reg <= CONVERT;
          end
        end
        CONVERT: begin
          if (finish_tick || abort_request || disable_request) begin
            state_reg <= IDLE;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // Counts half bit periods from the start; ticks only arrive while a conversion runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_count_reg <= 5'h00;
    end else if (start_request) begin
      half_count_reg <= 5'h00;
    end else if (half_tick) begin
      half_count_reg <= half_count_reg + 5'd1;
    end
  end

  // The top bit is tried first; each decision settles one bit and tries the next one down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_code_reg <= 10'h000;
    end else if (start_request) begin
      sar_code_reg <= 10'h200;
    end else if (decision_tick && busy) begin
      sar_code_reg <= sar_code_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_index_reg <= 4'h0;
    end else if (start_request) begin
      bit_index_reg <= 4'h9;
    end else if (decision_tick && busy && bit_index_reg != 4'd0) begin
      bit_index_reg <= bit_index_reg - 4'd1;
    end
  end

  // The latest decision is kept apart so that an abort can copy it into the unresolved bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_bit_reg <= 1'b0;
    end else if (start_request) begin
      last_bit_reg <= 1'b0;
    end else if (decision_tick && busy) begin
      last_bit_reg <= comparator_high;
    end
  end

  // Disabling the converter mid-conversion drops the sample and leaves the result untouched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_reg <= 2'h0;
      result_low_reg <= 8'h00;
    end else if (conversion_done) begin
      result_high_reg <= sar_code_reg[9:8];
      result_low_reg <= sar_code_reg[7:0];
    end else if (partial_store) begin
      result_high_reg <= partial_code[9:8];
      result_low_reg <= partial_code[7:0];
    end
  end

  // An abort reports on its own status bit so software can tell a partial result from a full one.
  assign conversion_done = busy && finish_tick && !abort_request && !disable_request;
  assign partial_store = abort_request && !disable_request;
  assign irq_events[POS_IRQ_DONE] = conversion_done;
  assign irq_events[POS_IRQ_ABORT] = partial_store;

  // Status bits are sticky and cleared by writing one; a new event outranks a clear.

  irq_status_bank irq_bank (
    .pclk(pclk),
    .presetn(presetn),
    .event_pulse(irq_events),
    .clear_write(write_irq_status),
    .mask_write(write_irq_mask),
    .write_bits(pwdata[1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );
  // The level output also serves as the wake request while asleep.

  // Routing and settling delays before a start are left to software.
  always_comb begin
    analog_ctrl.temp_sensor_power = ref_temp_reg[POS_TEMP_SENSOR_ENABLE];
    analog_ctrl.temp_range_high = ref_temp_reg[POS_TEMP_RANGE];
    analog_ctrl.fixed_ref_enable = ref_temp_reg[POS_FIXED_REF_ENABLE];
    analog_ctrl.fixed_ref_gain = ref_temp_reg[POS_FIXED_REF_GAIN_LSB +: 2];
    analog_ctrl.channel = control_0_reg[POS_CHANNEL_LSB +: CHANNEL_WIDTH];
    analog_ctrl.positive_ref = control_1_reg[POS_POS_REF_LSB +: 2];
    // The hold circuit tracks its input whenever the converter is on and idle.
    analog_ctrl.sampling = control_0_reg[POS_CONVERTER_ENABLE] && !busy;
    analog_ctrl.trial_code = sar_code_reg;
  end

endmodule
`default_nettype wire

/* File: testbench/analog_front_model.sv */
`default_nettype none
module analog_front_model
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire adc_ctrl_pkg::analog_ctrl_type analog_ctrl,
  output logic comparator_high,
  output logic rc_osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_reg;
  logic [2:0] rc_count_reg = 3'h0;

  // The held level is a function of the channel so each result names its source.
  always_ff @(posedge pclk) begin
    if (analog_ctrl.sampling) begin
      held_reg <= {analog_ctrl.channel, analog_ctrl.channel};
    end
  end

  assign comparator_high = held_reg >= analog_ctrl.trial_code;

  // The RC oscillator runs free, one half bit period every five cycles.
  always_ff @(posedge pclk) begin
    rc_count_reg <= (rc_count_reg == 3'h4) ? 3'h0 : rc_count_reg + 3'h1;
    rc_osc_tick <= rc_count_reg == 3'h4;
  end
endmodule
`default_nettype wire

/* File: testbench/sar_adc_temp_sense_control_assertions.sv */
`default_nettype none
module adc_ctrl_assertions
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comparator_high,
  input wire logic rc_osc_tick,
  input wire logic fixed_ref_ready,
  input wire adc_ctrl_pkg::analog_ctrl_type analog_ctrl,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence write_s(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence

  // Sampling high means enabled and idle, so this go is accepted.
  sequence start_s;
    write_s(OFFSET_CONTROL_0) ##0 (pwdata[1:0] == 2'b11 && analog_ctrl.sampling);
  endsequence

  pready_access_a: assert property (pready == (psel && penable))
    else $error("pready differs from access phase");
  unmapped_error_a: assert property (psel && penable |-> pslverr == (paddr[1:0] != 2'h0 || paddr > OFFSET_IRQ_MASK))
    else $error("pslverr wrong for address");
  sensor_power_a: assert property (
    write_s(OFFSET_REF_TEMP) |=> analog_ctrl.temp_sensor_power == $past(pwdata[POS_TEMP_SENSOR_ENABLE]))
    else $error("sensor power does not follow its bit");
  range_select_a: assert property (
    write_s(OFFSET_REF_TEMP) |=> analog_ctrl.temp_range_high == $past(pwdata[POS_TEMP_RANGE]))
    else $error("range select does not follow its bit");
  channel_route_a: assert property (
    write_s(OFFSET_CONTROL_0) |=> analog_ctrl.channel == $past(pwdata[6:2]))
    else $error("channel does not follow its field");
  disable_stop_a: assert property (
    write_s(OFFSET_CONTROL_0) ##0 !pwdata[POS_CONVERTER_ENABLE] |=> !analog_ctrl.sampling)
    else $error("sampling while converter disabled");
  conversion_hold_a: assert property (start_s |=> !analog_ctrl.sampling [*8])
    else $error("conversion ended too early");
  mask_quiet_a: assert property (
    write_s(OFFSET_IRQ_MASK) ##0 pwdata[1:0] == 2'h0 |=> !irq)
    else $error("irq high with all sources masked");
endmodule
`default_nettype wire

/* File: testbench/test_sar_adc_temp_sense_control.sv */
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module test_sar_adc_temp_sense_control;
  import adc_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fixed_ref_ready = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, comparator_high, rc_osc_tick, irq;
  analog_ctrl_type analog_ctrl;
  int n_mismatch = 0, checked = 0, cyc;
  logic [2:0] sel_tab [8] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_DIV16, CLK_DIV32, CLK_DIV64, 3'h3, 3'h7};
  int div_tab [8] = '{2, 4, 8, 16, 32, 64, 0, 0};
  logic [4:0] ch_tab [8] = '{5'h01, 5'h05, 5'h0a, 5'h13, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
  logic [1:0] ref_tab [3] = '{POS_REF_SUPPLY, POS_REF_PIN, POS_REF_FIXED};

  sar_adc_temp_sense_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_high(comparator_high), .rc_osc_tick(rc_osc_tick), .fixed_ref_ready(fixed_ref_ready),
    .analog_ctrl(analog_ctrl), .irq(irq));
  analog_front_model u_front (.pclk(pclk), .analog_ctrl(analog_ctrl), .comparator_high(comparator_high),
    .rc_osc_tick(rc_osc_tick));

  initial begin
    forever #4 pclk = ~pclk;
  end

  task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Irq is looked at on the falling edge, after the rising edge's updates have landed.
  task wait_irq;
    cyc = 0;
    while (irq !== 1'b1 && cyc < 3000) begin
      @(negedge pclk);
      cyc++;
    end
    if (cyc >= 3000) begin
      n_mismatch++;
      report_and_stop;
    end
    @(posedge pclk);
  endtask

  initial begin
    int exp, tol;
    logic [4:0] ch;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(OFFSET_CONTROL_0, {24'h0, RESET_CONTROL_0});
    chk_rd(OFFSET_CONTROL_1, {24'h0, RESET_CONTROL_1});
    chk_rd(OFFSET_REF_TEMP, {24'h0, RESET_REF_TEMP} | 32'h40);
    chk_rd(OFFSET_IRQ_MASK, {30'h0, RESET_IRQ_MASK});
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b1, OFFSET_REF_TEMP, 32'hb2);
    @(negedge pclk);
    `CHK({analog_ctrl.temp_sensor_power, analog_ctrl.temp_range_high, analog_ctrl.fixed_ref_gain}, 4'he)
    `CHK({analog_ctrl.fixed_ref_enable, analog_ctrl.fixed_ref_gain}, 3'h6)
    apb(1'b1, OFFSET_REF_TEMP, 32'h20);
    @(negedge pclk);
    `CHK({analog_ctrl.temp_sensor_power, analog_ctrl.temp_range_high}, 2'b10)
    @(posedge pclk);
    fixed_ref_ready <= 1'b0;
    chk_rd(OFFSET_REF_TEMP, 32'h20);
    apb(1'b1, OFFSET_IRQ_MASK, 32'h1);
    for (int i = 0; i < 8; i++) begin
      ch = ch_tab[i];
      apb(1'b1, OFFSET_CONTROL_1, {25'h0, sel_tab[i], 2'h0, ref_tab[i % 3]});
      apb(1'b1, OFFSET_CONTROL_0, {25'h0, ch, 2'b01});
      @(negedge pclk);
      `CHK({analog_ctrl.positive_ref, analog_ctrl.channel}, {ref_tab[i % 3], ch})
      repeat ((ch == CHANNEL_TEMP_SENSOR) ? 25000 : 20) @(posedge pclk);
      apb(1'b1, OFFSET_CONTROL_0, {25'h0, ch, 2'b11});
      wait_irq;
      exp = (div_tab[i] == 0) ? 115 : 23 * div_tab[i] / 2;
      tol = (div_tab[i] == 0) ? 7 : div_tab[i] / 2 + 2;
      `CHK(cyc + tol >= exp && cyc <= exp + tol, 1'b1)
      chk_rd(OFFSET_CONTROL_0, {25'h0, ch, 2'b01});
      chk_rd(OFFSET_RESULT_HIGH, {30'h0, ch[4:3]});
      chk_rd(OFFSET_RESULT_LOW, {24'h0, ch[2:0], ch});
      chk_rd(OFFSET_IRQ_STATUS, 32'h1);
      apb(1'b1, OFFSET_IRQ_STATUS, 32'h1);
      @(negedge pclk);
      `CHK(irq, 1'b0)
    end
    // Stopped after the first decision only: the other nine bits copy it.
    apb(1'b1, OFFSET_CONTROL_1, {25'h0, CLK_DIV64, 4'h0});
    apb(1'b1, OFFSET_CONTROL_0, {25'h0, 5'h12, 2'b01});
    repeat (20) @(posedge pclk);
    apb(1'b1, OFFSET_CONTROL_0, {25'h0, 5'h12, 2'b11});
    repeat (110) @(posedge pclk);
    apb(1'b1, OFFSET_CONTROL_0, {25'h0, 5'h12, 2'b01});
    chk_rd(OFFSET_RESULT_HIGH, 32'h3);
    chk_rd(OFFSET_RESULT_LOW, 32'hff);
    chk_rd(OFFSET_IRQ_STATUS, 32'h2);
    apb(1'b1, OFFSET_IRQ_STATUS, 32'h2);
    apb(1'b1, OFFSET_CONTROL_0, 32'h0);
    apb(1'b1, OFFSET_CONTROL_0, 32'h2);
    repeat (60) @(posedge pclk);
    chk_rd(OFFSET_CONTROL_0, 32'h0);
    chk_rd(OFFSET_IRQ_STATUS, 32'h0);
    apb(1'b1, OFFSET_CONTROL_0, 32'h3);
    chk_rd(OFFSET_CONTROL_0, 32'h1);
    apb(1'b1, OFFSET_CONTROL_1, {25'h0, CLK_DIV2, 4'h0});
    apb(1'b1, OFFSET_IRQ_MASK, 32'h0);
    apb(1'b1, OFFSET_CONTROL_0, 32'h3);
    repeat (60) @(posedge pclk);
    chk_rd(OFFSET_IRQ_STATUS, 32'h1);
    `CHK(irq, 1'b0)
    report_and_stop;
  end
endmodule

bind sar_adc_temp_sense_control adc_ctrl_assertions u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .comparator_high(comparator_high), .rc_osc_tick(rc_osc_tick),
  .fixed_ref_ready(fixed_ref_ready), .analog_ctrl(analog_ctrl), .irq(irq));
`undef CHK
`default_nettype wire
